/* File: logic/ssp_top.sv */
// Operation
// - data shifts in on serial clock rise
// - load strobe rise copies shift register out
// - strobe may stay high only if bit set
// - every primary word write starts calibration
// - reference divide only 1,2,4,8,16,32
// - phase detector compares divided ref, feedback
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"
module ssp_top
	import ssp_pkg::*;
#(
	parameter int CAL_REF_EDGES = 16,
	parameter int CAL_W         = 16
)(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        sclk,
	input  wire logic        sdata,
	input  wire logic        load_strobe,
	input  wire logic        reference_input,
	input  wire logic        feedback_input,
	output logic             pd_up,
	output logic             pd_dn,
	output logic             cal_busy,
	output logic             ref_div_out
);
	initial
	begin
		if (CAL_REF_EDGES < 1 || CAL_REF_EDGES * 8 >= (1 << CAL_W))
			$error("ssp_top: calibration count does not fit");
	end

	function automatic logic [31:0] word_reset(input int i);
		return (i == int'(`SSP_IDX_TOL)) ? `SSP_TOL_RST : 32'h0000_0000;
	endfunction

	ssp_pins_t pin_meta;
	ssp_pins_t pin_sync;
	ssp_pins_t pin_prev;
	wire ssp_pins_t pin_raw = '{sclk, sdata, load_strobe, reference_input, feedback_input};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_meta <= '0;
			pin_sync <= '0;
			pin_prev <= '0;
		end
		else
		begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	wire sclk_rise = pin_sync.sclk & ~pin_prev.sclk;
	wire le_rise   = pin_sync.load_strobe & ~pin_prev.load_strobe;
	wire ref_rise  = pin_sync.ref_in & ~pin_prev.ref_in;
	wire fb_rise   = pin_sync.fb_in & ~pin_prev.fb_in;

	logic [31:0]      ctrl;
	logic [31:0]      shreg;
	logic [31:0]      cw [`SSP_NWORDS];
	ssp_status_t      stat;
	ssp_cal_state_t   cal_state;
	logic [CAL_W-1:0] cal_cnt;
	logic [7:0]       load_count;
	logic [3:0]       last_addr;

	wire        port_en   = ctrl[0];
	wire        pd_en     = ctrl[1];
	wire        tol_bit   = cw[`SSP_IDX_TOL][`SSP_TOL_BIT];
	wire [3:0]  load_addr = shreg[`SSP_ADDR_W-1:0];
	wire        held      = pin_sync.load_strobe & tol_bit;
	wire        shift_ok  = sclk_rise & port_en & ~held;
	wire        load_ok   = le_rise & port_en;
	wire        cal_start = load_ok & (load_addr == `SSP_IDX_PRIM);
	wire [21:0] den       = cw[`SSP_IDX_DEN][`SSP_DEN_HI:`SSP_DEN_LO];
	wire [2:0]  rdiv_code = cw[`SSP_IDX_RDIV][`SSP_RDIV_HI:`SSP_RDIV_LO];
	wire [1:0]  cal_div   = cw[`SSP_IDX_CALDIV][`SSP_CALDIV_HI:`SSP_CALDIV_LO];
	wire [CAL_W-1:0] cal_len = CAL_W'(CAL_REF_EDGES) << cal_div;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			shreg <= '0;
		else if (shift_ok)
			shreg <= {shreg[30:0], pin_sync.sdata};
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < `SSP_NWORDS; i++)
				cw[i] <= word_reset(i);
		end
		else if (load_ok)
			cw[load_addr] <= shreg;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			load_count <= '0;
			last_addr  <= '0;
		end
		else if (load_ok)
		begin
			load_count <= load_count + 8'h01;
			last_addr  <= load_addr;
		end
	end

	// calibration restart on every primary load
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cal_state <= CAL_IDLE;
			cal_cnt   <= '0;
		end
		else if (cal_start)
		begin
			cal_state <= CAL_RUN;
			cal_cnt   <= cal_len;
		end
		else
		begin
			case (cal_state)
				CAL_IDLE: cal_cnt <= '0;
				CAL_RUN:
				begin
					if (ref_rise)
					begin
						cal_cnt <= cal_cnt - CAL_W'(1);
						if (cal_cnt == CAL_W'(1))
							cal_state <= CAL_IDLE;
					end
				end
				default: cal_state <= CAL_IDLE;
			endcase
		end
	end

	assign cal_busy = (cal_state == CAL_RUN);

	ssp_ref_div #(
		.CNT_W (6)
	) u_ref_div (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ref_rise  (ref_rise),
		.div_code  (rdiv_code),
		.div_pulse (ref_div_out)
	);

	wire up_set = ref_div_out & pd_en;
	wire dn_set = fb_rise & pd_en;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pd_up <= 1'b0;
			pd_dn <= 1'b0;
		end
		else if ((pd_up | up_set) & (pd_dn | dn_set))
		begin
			pd_up <= 1'b0;
			pd_dn <= 1'b0;
		end
		else
		begin
			pd_up <= pd_up | up_set;
			pd_dn <= pd_dn | dn_set;
		end
	end

	assign stat = '{
		load_count:     load_count,
		last_addr:      last_addr,
		den_restricted: (rdiv_code > `SSP_RDIV_BIG),
		den_invalid:    (den < `SSP_DEN_MIN),
		load_held:      held,
		cal_busy:       cal_busy
	};

	wire        ap_take  = hsel & htrans[1] & hready;
	wire [7:0]  ap_addr  = haddr[7:0];
	wire        in_words = (ap_addr >= `SSP_OFS_WORDS) && (ap_addr < `SSP_OFS_END)
	                       && (ap_addr[1:0] == 2'b00) && (haddr[31:8] == 24'h00_0000);
	wire [3:0]  word_idx = 4'(ap_addr[5:2]);
	logic       dp_wr;
	logic [7:0] dp_addr;
	logic [31:0] rd_mux;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (haddr[31:8] == 24'h00_0000)
		begin
			case (ap_addr)
				`SSP_OFS_CTRL:  rd_mux = ctrl;
				`SSP_OFS_STAT:  rd_mux = {16'h0000, stat};
				`SSP_OFS_SHIFT: rd_mux = shreg;
				default:        rd_mux = in_words ? cw[word_idx] : 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_wr   <= 1'b0;
			dp_addr <= '0;
			hrdata  <= '0;
		end
		else
		begin
			dp_wr   <= ap_take & hwrite & (haddr[31:8] == 24'h00_0000);
			dp_addr <= ap_addr;
			if (ap_take & ~hwrite)
				hrdata <= rd_mux;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl <= `SSP_CTRL_RST;
		else if (dp_wr && dp_addr == `SSP_OFS_CTRL)
			ctrl <= {30'h0000_0000, hwdata[1:0]};
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_shift_capture;
		shift_ok |=> shreg[0] == $past(pin_sync.sdata);
	endproperty
	a_shift_capture: assert property (p_shift_capture) else $error("bit not captured");

	property p_msb_first;
		shift_ok |=> shreg[31:1] == $past(shreg[30:0]);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("shift order wrong");

	sequence s_prim_load;
		load_ok && load_addr == `SSP_IDX_PRIM;
	endsequence
	property p_load_transfer;
		s_prim_load |=> cw[`SSP_IDX_PRIM] == $past(shreg);
	endproperty
	a_load_transfer: assert property (p_load_transfer) else $error("word not loaded");

	property p_tol_hold;
		(sclk_rise && pin_sync.load_strobe && tol_bit) |=> $stable(shreg);
	endproperty
	a_tol_hold: assert property (p_tol_hold) else $error("shift while held");

	property p_cal_start;
		s_prim_load |=> cal_busy && cal_cnt == $past(cal_len);
	endproperty
	a_cal_start: assert property (p_cal_start) else $error("calibration not started");

	property p_no_load_stable;
		!le_rise |=> $stable(cw[`SSP_IDX_PRIM]) && $stable(cw[`SSP_IDX_TOL]);
	endproperty
	a_no_load_stable: assert property (p_no_load_stable) else $error("word changed");

	property p_pd_compare;
		(pd_en && ref_div_out && !fb_rise && !pd_dn) |=> pd_up ##1 (pd_up == !$past(dn_set));
	endproperty
	a_pd_compare: assert property (p_pd_compare) else $error("phase up missing");
endmodule // ssp_top
`default_nettype wire

/* File: logic/ssp_defines.svh */
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
`define SSP_WORD_W     32
`define SSP_ADDR_W     4
`define SSP_NWORDS     16
`define SSP_IDX_PRIM   4'h0
`define SSP_IDX_DEN    4'h1
`define SSP_IDX_TOL    4'h5
`define SSP_IDX_CALDIV 4'h7
`define SSP_IDX_RDIV   4'h8
`define SSP_TOL_BIT    23
`define SSP_DEN_HI     25
`define SSP_DEN_LO     4
`define SSP_CALDIV_HI  9
`define SSP_CALDIV_LO  8
`define SSP_RDIV_HI    10
`define SSP_RDIV_LO    8
`define SSP_TOL_RST    32'h0080_0000
`define SSP_DEN_MIN    22'h00_0002
`define SSP_RDIV_MAXC  3'h5
`define SSP_RDIV_BIG   3'h3
`define SSP_OFS_CTRL   8'h00
`define SSP_OFS_STAT   8'h04
`define SSP_OFS_SHIFT  8'h08
`define SSP_OFS_WORDS  8'h40
`define SSP_OFS_END    8'h80
`define SSP_CTRL_RST   32'h0000_0003
`endif

/* File: logic/ssp_pkg.sv */
package ssp_pkg;
	typedef struct packed {
		logic sclk;
		logic sdata;
		logic load_strobe;
		logic ref_in;
		logic fb_in;
	} ssp_pins_t;
	typedef struct packed {
		logic [7:0] load_count;
		logic [3:0] last_addr;
		logic       den_restricted;
		logic       den_invalid;
		logic       load_held;
		logic       cal_busy;
	} ssp_status_t;
	typedef enum logic {
		CAL_IDLE = 1'b0,
		CAL_RUN  = 1'b1
	} ssp_cal_state_t;
endpackage

/* File: logic/ssp_ref_div.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"
module ssp_ref_div
	import ssp_pkg::*;
#(
	parameter int CNT_W = 6
)(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       ref_rise,
	input  wire logic [2:0] div_code,
	output logic            div_pulse
);
	initial
	begin
		if (CNT_W < 6)
			$error("ssp_ref_div: CNT_W too small");
	end

	function automatic logic [CNT_W-1:0] div_value(input logic [2:0] c);
		logic [2:0] k;
		k = (c > `SSP_RDIV_MAXC) ? `SSP_RDIV_MAXC : c;
		return CNT_W'(1) << k;
	endfunction

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] seen;
	logic [2:0]       code_q;
	logic             steady;
	wire  [CNT_W-1:0] dval = div_value(div_code);
	wire              last = (cnt >= dval - CNT_W'(1));

	assign div_pulse = ref_rise & last;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cnt <= '0;
		else if (ref_rise)
			cnt <= last ? '0 : cnt + CNT_W'(1);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			seen <= '0;
		else if (div_pulse)
			seen <= '0;
		else if (ref_rise)
			seen <= seen + CNT_W'(1);
	end

	// ratio check only once aligned after a code change
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			code_q <= '0;
		else
			code_q <= div_code;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			steady <= 1'b0;
		else if (div_code != code_q)
			steady <= 1'b0;
		else if (div_pulse)
			steady <= 1'b1;
	end

	property p_div_ratio;
		@(posedge hclk) disable iff (!hresetn)
		(div_pulse && steady && div_code == code_q) |-> (seen + CNT_W'(1) == dval);
	endproperty
	a_div_ratio: assert property (p_div_ratio) else $error("divide ratio wrong");
endmodule // ssp_ref_div
`default_nettype wire

/* File: testbench/ssp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ssp_host_model (
	output logic sclk,
	output logic sdata,
	output logic load_strobe
);
	initial
	begin
		sclk = 1'b0;
		sdata = 1'b0;
		load_strobe = 1'b0;
	end
	task automatic shift(input logic [31:0] w);
		#5;
		for (int i = 31; i >= 0; i--)
		begin
			sdata = w[i];
			#40 sclk = 1'b1;
			#80 sclk = 1'b0;
			#40;
		end
		sdata = 1'b0;
	endtask
	task automatic strobe(input logic hold);
		#5 load_strobe = 1'b1;
		#80 load_strobe = hold;
		#80;
	endtask
endmodule // ssp_host_model
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"
module tb;
	localparam int          CAL_EDGES = 16;
	localparam logic [31:0] A_STAT    = 32'h0000_0004;
	logic        hclk, hresetn, hsel, hwrite, sdata, sclk, load_strobe;
	logic        reference_input, feedback_input, hreadyout, hresp;
	logic        pd_up, pd_dn, cal_busy, ref_div_out, fb_on;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, d;
	int          n_errors, checked, n, e;

	ssp_top #(.CAL_REF_EDGES(CAL_EDGES)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.sclk(sclk), .sdata(sdata), .load_strobe(load_strobe),
		.reference_input(reference_input), .feedback_input(feedback_input),
		.pd_up(pd_up), .pd_dn(pd_dn), .cal_busy(cal_busy), .ref_div_out(ref_div_out));
	ssp_host_model host (.sclk(sclk), .sdata(sdata), .load_strobe(load_strobe));

	initial
	begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	initial
	begin
		reference_input = 1'b0;
		#5;
		forever #50 reference_input = ~reference_input;
	end
	initial
	begin
		feedback_input = 1'b0;
		#2;
		forever #70 feedback_input = fb_on & ~feedback_input;
	end

	task automatic wrap_up();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		htrans <= 2'b10;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		hsize <= 3'h0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		d = hrdata;
	endtask
	task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, d & m, exp);
		chk("resp", 32'(hresp), 32'h0000_0000);
	endtask
	function automatic logic [31:0] wa(input int i);
		return 32'(`SSP_OFS_WORDS) + 32'(i * 4);
	endfunction
	task automatic send(input logic [31:0] w);
		@(posedge hclk);
		host.shift(w);
	endtask
	task automatic fire(input logic h);
		@(posedge hclk);
		host.strobe(h);
	endtask
	task automatic load(input logic [31:0] w);
		send(w);
		fire(1'b0);
	endtask
	task automatic gap();
		@(posedge hclk);
		n = 1;
		while (ref_div_out !== 1'b1 && n < 400)
		begin
			@(posedge hclk);
			n++;
		end
	endtask

	initial
	begin
		repeat (20000) @(posedge hclk);
		n_errors++;
		wrap_up();
	end
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		n_errors = 0;
		checked = 0;
		fb_on = 1'b1;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk("ctrl", 32'h0000_0000, 32'hffff_ffff, `SSP_CTRL_RST);
		rchk("tol word", wa(5), 32'hffff_ffff, `SSP_TOL_RST);
		rchk("status", A_STAT, 32'h0000_000f, 32'h0000_0004);
		rchk("unmapped", 32'h0000_0100, 32'hffff_ffff, 32'h0000_0000);
		$display("done reset");
		send(32'ha5c3_0f13);
		rchk("shreg", 32'(`SSP_OFS_SHIFT), 32'hffff_ffff, 32'ha5c3_0f13);
		rchk("no strobe", wa(3), 32'hffff_ffff, 32'h0000_0000);
		fire(1'b0);
		rchk("word3", wa(3), 32'hffff_ffff, 32'ha5c3_0f13);
		rchk("last idx", A_STAT, 32'h0000_00f0, 32'h0000_0030);
		$display("done load");
		bus(1'b1, 32'h0000_0000, 32'h0000_0002);
		rchk("ctrl rw", 32'h0000_0000, 32'hffff_ffff, 32'h0000_0002);
		load(32'h1111_1113);
		rchk("disabled", wa(3), 32'hffff_ffff, 32'ha5c3_0f13);
		bus(1'b1, 32'h0000_0000, 32'h0000_0003);
		$display("done enable");
		send(32'h0000_0022);
		fire(1'b1);
		rchk("held", A_STAT, 32'h0000_0002, 32'h0000_0002);
		send(32'hffff_ffff);
		rchk("held shift", 32'(`SSP_OFS_SHIFT), 32'hffff_ffff, 32'h0000_0022);
		fire(1'b0);
		rchk("released", A_STAT, 32'h0000_0002, 32'h0000_0000);
		load(32'h0000_0051);
		rchk("den ok", A_STAT, 32'h0000_0004, 32'h0000_0000);
		$display("done strobe");
		for (int c = 0; c < 6; c++)
		begin
			load(32'h0000_0018 | 32'(c << 8));
			rchk("big div", A_STAT, 32'h0000_0008, (c > 3) ? 32'h8 : 32'h0);
			gap();
			gap();
			chk("div gap", 32'(n), 32'(5 << c));
		end
		fb_on = 1'b0;
		gap();
		gap();
		gap();
		chk("pd state", 32'({pd_up, pd_dn}), 32'h0000_0002);
		fb_on = 1'b1;
		$display("done divider");
		for (int cd = 0; cd < 2; cd++)
		begin
			load(32'h0012_3407 | 32'(cd << 8));
			rchk("cal word", wa(7), 32'hffff_ffff, 32'h0012_3407 | 32'(cd << 8));
			load(32'h0000_1230);
			chk("cal start", 32'(cal_busy), 32'h1);
			e = (CAL_EDGES << cd) * 5;
			n = 0;
			while (cal_busy === 1'b1 && n < 2000)
			begin
				@(posedge hclk);
				n++;
			end
			chk("cal len", 32'(n > e - 16 && n <= e), 32'h1);
			load(32'h0000_1230);
			chk("cal again", 32'(cal_busy), 32'h1);
			rchk("cal stat", A_STAT, 32'h0000_0001, 32'h0000_0001);
			wait (cal_busy !== 1'b1);
		end
		rchk("alias", 32'h0000_0080, 32'hffff_ffff, 32'h0000_0000);
		$display("done calibration");
		@(posedge hclk);
		wrap_up();
	end
endmodule // tb
`default_nettype wire
